/* File: logic/lcd_pkg.sv */
// Shared constants for the display host port: timing, RAM geometry,
// command codes and pin vector layout.
// Assumes a 50 MHz system clock on both ends.
package lcd_pkg;
  //////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_NS     = 20;
  localparam int STROBE_NS  = 160;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCL_NS     = 160;
  localparam int SCL_HALF   = SCL_NS / (2 * CLK_NS);
  localparam int SETUP_CYC  = 2;
  localparam int HOLD_CYC   = 2;
  localparam int GAP_CYC    = 8;
  localparam int BUSY_CYC   = 4;
  localparam int CNT_W      = 4;
  //////////////////////////////////////////////////////////////////////
  // Display RAM geometry
  localparam int          NUM_PAGES  = 9;
  localparam int          NUM_COLS   = 132;
  localparam int          RAM_WORDS  = NUM_PAGES * NUM_COLS;
  localparam logic [7:0]  COL_LAST   = 8'h83;
  localparam logic [3:0]  PAGE_EXTRA = 4'h8;
  localparam logic [6:0]  NUM_LINES  = 7'h41;
  localparam logic [6:0]  COM_LAST   = 7'h3F;
  localparam logic [6:0]  COM_EXTRA  = 7'h40;
  localparam logic [7:0]  EXTRA_MASK = 8'h01;
  localparam logic [2:0]  BIT_LAST   = 3'h7;
  localparam int          BUSY_BIT   = 7;
  //////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [3:0] CMD_COL_LO   = 4'h0;
  localparam logic [3:0] CMD_COL_HI   = 4'h1;
  localparam logic [3:0] CMD_PAGE     = 4'hB;
  localparam logic [1:0] CMD_LINE     = 2'h1;
  localparam logic [7:0] CMD_SEG_NORM = 8'hA0;
  localparam logic [7:0] CMD_SEG_REV  = 8'hA1;
  localparam logic [7:0] CMD_COM_NORM = 8'hC0;
  localparam logic [7:0] CMD_COM_REV  = 8'hC8;
  //////////////////////////////////////////////////////////////////////
  // Pin positions in the data bus during serial mode
  localparam int SER_DATA_BIT = 7;
  localparam int SER_CLK_BIT  = 6;
endpackage : lcd_pkg

/* File: logic/lcd_bus_if.sv */
// Pin bundle between host microprocessor and display port.
// Assumes the bench resolves the shared data wire from the enables.
`timescale 1ns/1ps
interface lcd_bus_if;
  // Straps
  logic       parallel_select;
  logic       bus_style_strap;
  // Selects and strobes
  logic       chip_select_low_active_n;
  logic       chip_select_high_active;
  logic       command_data_select;
  logic       rd_e;
  logic       wr_rw;
  // Data bus, split into both directions
  logic [7:0] data_host;
  logic       data_host_oe;
  logic [7:0] data_dev;
  logic       data_dev_oe;

  modport device (
    input  parallel_select, bus_style_strap, chip_select_low_active_n,
           chip_select_high_active, command_data_select, rd_e, wr_rw,
           data_host, data_host_oe,
    output data_dev, data_dev_oe
  );
  modport host (
    output parallel_select, bus_style_strap, chip_select_low_active_n,
           chip_select_high_active, command_data_select, rd_e, wr_rw,
           data_host, data_host_oe,
    input  data_dev, data_dev_oe
  );
endinterface : lcd_bus_if

/* File: logic/lcd_port_host.sv */
// Host end: turns queued requests into bus cycles or serial bytes.
// Assumes the device keeps pace with the strobe and gap lengths below.
`timescale 1ns/1ps
module lcd_port_host (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Straps chosen by the board
  input  wire logic       parallel_mode,
  input  wire logic       bus_style,
  // Request
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic       cmd_cd,
  input  wire logic [7:0] cmd_data,
  // Answer
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  // Pins
  lcd_bus_if.host         bus
);
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_SETUP  = 5'b00010,
    ST_STROBE = 5'b00100,
    ST_HOLD   = 5'b01000,
    ST_GAP    = 5'b10000
  } host_state_t;

  host_state_t                state_r;
  logic [lcd_pkg::CNT_W-1:0]  cnt_r;
  logic [2:0]                 bit_r;
  logic                       sclk_r;
  logic [7:0]                 shift_r;
  logic                       rd_r;
  logic                       cd_r;
  logic [7:0]                 dev_s1_r;
  logic [7:0]                 dev_s2_r;

  //////////////////////////////////////////////////////////////////////
  // Returned data pins pass two flops before use
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dev_s1_r <= 8'h00;
      dev_s2_r <= 8'h00;
    end else begin
      dev_s1_r <= bus.data_dev;
      dev_s2_r <= dev_s1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r   <= ST_IDLE;
      cnt_r     <= '0;
      bit_r     <= '0;
      sclk_r    <= 1'b0;
      shift_r   <= 8'h00;
      rd_r      <= 1'b0;
      cd_r      <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      cnt_r     <= cnt_r + 1'b1;
      case (state_r)
        ST_IDLE: begin
          cnt_r <= '0;
          bit_r <= '0;
          if (cmd_valid) begin
            shift_r <= cmd_data;
            rd_r    <= cmd_read;
            cd_r    <= cmd_cd;
            state_r <= (cmd_read && !parallel_mode) ? ST_GAP : ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_r == lcd_pkg::CNT_W'(lcd_pkg::SETUP_CYC - 1)) begin
            cnt_r   <= '0;
            state_r <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (parallel_mode) begin
            if (cnt_r == lcd_pkg::CNT_W'(lcd_pkg::STROBE_CYC - 1)) begin
              cnt_r     <= '0;
              rsp_valid <= rd_r;
              rsp_data  <= dev_s2_r;
              state_r   <= ST_HOLD;
            end
          end else if (cnt_r == lcd_pkg::CNT_W'(lcd_pkg::SCL_HALF - 1)) begin
            cnt_r  <= '0;
            sclk_r <= !sclk_r;
            if (sclk_r) begin
              shift_r <= {shift_r[6:0], 1'b0};
              bit_r   <= bit_r + 1'b1;
              if (bit_r == lcd_pkg::BIT_LAST) begin
                state_r <= ST_HOLD;
              end
            end
          end
        end
        ST_HOLD: begin
          if (cnt_r == lcd_pkg::CNT_W'(lcd_pkg::HOLD_CYC - 1)) begin
            cnt_r   <= '0;
            state_r <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (cnt_r == lcd_pkg::CNT_W'(lcd_pkg::GAP_CYC - 1)) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pin drive
  logic sel;
  logic strobe;
  assign sel       = (state_r == ST_SETUP) || (state_r == ST_STROBE)
                  || (state_r == ST_HOLD);
  assign strobe    = parallel_mode && (state_r == ST_STROBE);
  assign cmd_ready = (state_r == ST_IDLE);

  assign bus.parallel_select          = parallel_mode;
  assign bus.bus_style_strap          = bus_style;
  assign bus.chip_select_low_active_n = !sel;
  assign bus.chip_select_high_active  = sel;
  assign bus.command_data_select      = cd_r;
  // 6800 uses E and R/W level
  // unused strobes held high in serial
  assign bus.rd_e  = !parallel_mode ? 1'b1
                   : bus_style ? strobe : !(strobe && rd_r);
  assign bus.wr_rw = !parallel_mode ? 1'b1
                   : bus_style ? rd_r : !(strobe && !rd_r);
  assign bus.data_host = parallel_mode ? shift_r
                       : {shift_r[7], sclk_r, 6'h00};
  assign bus.data_host_oe = sel && (!parallel_mode || !rd_r);
endmodule : lcd_port_host

/* File: logic/lcd_port_dev.sv */
// Display driver host port with page/column addressed display RAM and an
// independent refresh read port.
// Assumes all pins arrive asynchronously; refresh side is on clk.
`timescale 1ns/1ps
// Function
// - strap picks parallel or write-only serial
// - style strap picks 6800 or 8080 strobes
// - select high means RAM data, low command/status
// - serial bits sampled on clock rise, MSB first
// - eighth serial rise delivers the byte
// - select sampled on each eighth serial rise
// - deselect clears shifter and bit counter
// - unselected means data released, inputs ignored
// - 8080 write data taken at strobe rise
// - first read after address/write is dummy
// - written byte held, then committed to RAM
// - status read shows busy on bit 7
// - while busy only status reads act
// - page 8 keeps only bit 0
// - column steps after each data access
// - column stops at last, never wraps
// - segment direction reverses column mapping
// - start line feeds first or last common
// - 65 lines shown from start line
// - refresh reads on its own port
// - host holds unused inputs fixed
module lcd_port_dev (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Pins
  lcd_bus_if.device       bus,
  // Refresh side
  input  wire logic [6:0] refresh_com,
  input  wire logic [7:0] refresh_seg,
  output logic            refresh_pixel,
  // State seen by the driver
  output logic            busy,
  output logic            seg_reverse,
  output logic            com_reverse,
  output logic [5:0]      start_line
);
  //////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [10:0] ram_index(input logic [3:0] page,
                                            input logic [7:0] col);
    ram_index = 11'(page * lcd_pkg::NUM_COLS + col);
  endfunction : ram_index
  function automatic logic [7:0] page_mask(input logic [3:0] page,
                                           input logic [7:0] val);
    page_mask = (page == lcd_pkg::PAGE_EXTRA) ? (val & lcd_pkg::EXTRA_MASK)
                                              : val;
  endfunction : page_mask
  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [14:0] pin_s1_r;
  logic [14:0] pin_s2_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {bus.parallel_select, bus.bus_style_strap,
                   bus.chip_select_low_active_n, bus.chip_select_high_active,
                   bus.command_data_select, bus.rd_e, bus.wr_rw,
                   bus.data_host};
      pin_s2_r <= pin_s1_r;
    end
  end
  logic       par, style, sel, cd, rde, wrw;
  logic [7:0] dat;
  assign par   = pin_s2_r[14];
  assign style = pin_s2_r[13];
  assign sel   = !pin_s2_r[12] && pin_s2_r[11];
  assign cd    = pin_s2_r[10];
  assign rde   = pin_s2_r[9];
  assign wrw   = pin_s2_r[8];
  assign dat   = pin_s2_r[7:0];
  //////////////////////////////////////////////////////////////////////
  // Parallel strobe decode
  logic act_now, is_rd, act_q_r, rd_q_r, cd_q_r;
  // E high or either strobe low
  assign act_now = sel && par && (style ? rde : (!rde || !wrw));
  assign is_rd   = style ? wrw : !rde;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      act_q_r <= 1'b0;
      rd_q_r  <= 1'b0;
      cd_q_r  <= 1'b0;
    end else begin
      act_q_r <= act_now;
      if (act_now && !act_q_r) begin
        rd_q_r <= is_rd;
        cd_q_r <= cd;
      end
    end
  end
  logic acc_start, acc_end;
  assign acc_start = act_now && !act_q_r;
  assign acc_end   = !act_now && act_q_r;
  //////////////////////////////////////////////////////////////////////
  // Serial shifter
  logic [6:0] shift_r;
  logic [2:0] bits_r;
  logic       sclk_q_r, sclk_rise;
  assign sclk_rise = sel && !par && dat[lcd_pkg::SER_CLK_BIT] && !sclk_q_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_r  <= '0;
      bits_r   <= '0;
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= dat[lcd_pkg::SER_CLK_BIT];
      if (!sel || par) begin
        shift_r <= '0;
        bits_r  <= '0;
      end else if (sclk_rise) begin
        shift_r <= {shift_r[5:0], dat[lcd_pkg::SER_DATA_BIT]};
        bits_r  <= bits_r + 1'b1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Incoming byte and busy
  logic       ser_done, par_wr, wr_ev, wr_cd, accept;
  logic [7:0] wr_byte;
  logic [2:0] busy_cnt_r;
  assign ser_done = sclk_rise && (bits_r == lcd_pkg::BIT_LAST);
  assign par_wr   = acc_end && !rd_q_r;
  assign wr_ev    = ser_done || par_wr;
  assign wr_byte  = par ? dat : {shift_r, dat[lcd_pkg::SER_DATA_BIT]};
  // serial select sampled at eighth rise
  assign wr_cd    = par ? cd_q_r : cd;
  // nothing but status reads while busy
  assign accept   = wr_ev && !busy;
  assign busy     = (busy_cnt_r != 3'h0);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_cnt_r <= 3'h0;
    end else if (accept) begin
      busy_cnt_r <= 3'(lcd_pkg::BUSY_CYC);
    end else if (busy) begin
      busy_cnt_r <= busy_cnt_r - 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Command registers and column counter
  logic [3:0] page_r;
  logic [7:0] col_r, wr_hold_r;
  logic       wr_pend_r, rd_step;
  assign rd_step = acc_end && rd_q_r && cd_q_r && !busy;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      page_r      <= 4'h0;
      col_r       <= 8'h00;
      start_line  <= 6'h00;
      seg_reverse <= 1'b0;
      com_reverse <= 1'b0;
      wr_hold_r   <= 8'h00;
      wr_pend_r   <= 1'b0;
    end else begin
      if (wr_pend_r) begin
        wr_pend_r <= 1'b0;
      end
      if (accept && wr_cd) begin
        wr_hold_r <= wr_byte;
        wr_pend_r <= 1'b1;
      end else if (accept) begin
        case (wr_byte[7:4])
          lcd_pkg::CMD_COL_LO: col_r[3:0] <= wr_byte[3:0];
          lcd_pkg::CMD_COL_HI: col_r[7:4] <= wr_byte[3:0];
          lcd_pkg::CMD_PAGE: begin
            if (wr_byte[3:0] <= lcd_pkg::PAGE_EXTRA) begin
              page_r <= wr_byte[3:0];
            end
          end
          default: begin
            if (wr_byte[7:6] == lcd_pkg::CMD_LINE) begin
              start_line <= wr_byte[5:0];
            end
            if (wr_byte == lcd_pkg::CMD_SEG_NORM) seg_reverse <= 1'b0;
            if (wr_byte == lcd_pkg::CMD_SEG_REV)  seg_reverse <= 1'b1;
            if (wr_byte == lcd_pkg::CMD_COM_NORM) com_reverse <= 1'b0;
            if (wr_byte == lcd_pkg::CMD_COM_REV)  com_reverse <= 1'b1;
          end
        endcase
      end
      if ((wr_pend_r || rd_step) && (col_r < lcd_pkg::COL_LAST)) begin
        col_r <= col_r + 1'b1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Display RAM, host port
  // nine pages of 132 bytes
  logic [7:0] mem [0:lcd_pkg::RAM_WORDS-1];
  logic       col_ok;
  assign col_ok = (col_r <= lcd_pkg::COL_LAST);
  always_ff @(posedge clk) begin
    // extra page stores bit 0 only
    if (wr_pend_r && col_ok) begin
      mem[ram_index(page_r, col_r)] <= page_mask(page_r, wr_hold_r);
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Read holder and bus output
  logic [7:0] rd_hold_r;
  logic [7:0] dout_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_hold_r <= 8'h00;
      dout_r    <= 8'h00;
    end else begin
      // holder reloaded after each data read made while not busy
      if (rd_step) begin
        rd_hold_r <= col_ok ? page_mask(page_r, mem[ram_index(page_r, col_r)])
                            : 8'h00;
      end
      if (acc_start && is_rd) begin
        dout_r <= 8'h00;
        if (!cd) dout_r[lcd_pkg::BUSY_BIT] <= busy;
        else     dout_r <= rd_hold_r;
      end
    end
  end
  // reads exist only in parallel mode
  assign bus.data_dev    = dout_r;
  assign bus.data_dev_oe = act_q_r && act_now && rd_q_r;
  //////////////////////////////////////////////////////////////////////
  // Refresh port
  logic [6:0] line_sel, line_sum, ram_line;
  logic [7:0] ref_col;
  logic [3:0] ref_page;
  assign line_sel = (refresh_com >= lcd_pkg::COM_EXTRA) ? lcd_pkg::COM_EXTRA
                  : com_reverse ? (lcd_pkg::COM_LAST - refresh_com) : refresh_com;
  assign line_sum = {1'b0, start_line} + line_sel;
  assign ram_line = (line_sum >= lcd_pkg::NUM_LINES)
                  ? (line_sum - lcd_pkg::NUM_LINES) : line_sum;
  assign ref_col  = seg_reverse ? (lcd_pkg::COL_LAST - refresh_seg) : refresh_seg;
  assign ref_page = ram_line[6:3];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      refresh_pixel <= 1'b0;
    end else if (refresh_seg <= lcd_pkg::COL_LAST) begin
      refresh_pixel <= mem[ram_index(ref_page, ref_col)][ram_line[2:0]];
    end else begin
      refresh_pixel <= 1'b0;
    end
  end
endmodule : lcd_port_dev

/* File: sim/lcd_host_port_chk.sv */
// Pin-level checks between the host end and the display port.
// Assumes both ends sit on one pin bundle and nrst is active low.
`timescale 1ns/1ps
module lcd_host_port_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Straps and selects
  input wire logic       parallel_select,
  input wire logic       bus_style_strap,
  input wire logic       chip_select_low_active_n,
  input wire logic       chip_select_high_active,
  input wire logic       command_data_select,
  // Strobes and data
  input wire logic       rd_e,
  input wire logic       wr_rw,
  input wire logic [7:0] data_host,
  input wire logic       data_host_oe,
  input wire logic [7:0] data_dev,
  input wire logic       data_dev_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////////////
  // Chip selected
  logic sel;
  assign sel = !chip_select_low_active_n && chip_select_high_active;
  //////////////////////////////////////////////////////////////////////
  // Device side
  dev_release_a: assert property (!sel [*5] |-> !data_dev_oe)
    else $error("device drives data while not selected");
  serial_noread_a: assert property (!parallel_select [*5] |-> !data_dev_oe)
    else $error("device drives data in serial mode");
  wr_no_drive_a: assert property ((parallel_select && !bus_style_strap && !wr_rw) [*5]
    |-> !data_dev_oe) else $error("device drives data during a write");
  read_low_a: assert property (parallel_select && !bus_style_strap && sel && wr_rw
    && $fell(rd_e) |-> ##[1:6] data_dev_oe) else $error("no answer to low read strobe");
  read_enable_a: assert property (parallel_select && bus_style_strap && sel && wr_rw
    && $rose(rd_e) |-> ##[1:6] data_dev_oe) else $error("no answer to enable read");
  status_bits_a: assert property ($rose(data_dev_oe) && !command_data_select
    |-> data_dev[6:0] == 7'h00) else $error("status low bits not zero");
  // Host side
  sclk_idle_a: assert property (!parallel_select && $stable(parallel_select) && !sel
    |-> !$rose(data_host[6])) else $error("serial clock moves while deselected");
  ser_setup_a: assert property (!parallel_select && $stable(parallel_select)
    && $rose(data_host[6]) |-> $stable(data_host[7]) && $stable(command_data_select))
    else $error("serial data or select changes at clock rise");
  wr_hold_a: assert property (parallel_select && !bus_style_strap && $rose(wr_rw)
    |-> $stable(data_host) && data_host_oe) else $error("write data moves at strobe end");
  host_contend_a: assert property (parallel_select && !bus_style_strap && !rd_e
    |-> !data_host_oe) else $error("host drives data during a read");
  strap_fixed_a: assert property (!parallel_select && $stable(parallel_select)
    |-> $stable(rd_e) && $stable(wr_rw) && $stable(bus_style_strap))
    else $error("unused strobe or strap moves in serial mode");
  // Main scenarios
  cover property (parallel_select && !bus_style_strap && sel && $rose(wr_rw));
  cover property (!parallel_select && sel && $rose(data_host[6]));
  cover property ($rose(data_dev_oe) && bus_style_strap);
endmodule : lcd_host_port_chk

/* File: sim/lcd_host_port_ram_access_bench.sv */
// Self-checking bench: host end and display port joined by the pin bundle.
// Assumes a 50 MHz clock and a fixed seed for repeatable random data.
`timescale 1ns/1ps
module lcd_host_port_ram_access_bench;
  logic       clk, nrst, parallel_mode, bus_style, cmd_valid, cmd_ready;
  logic       cmd_read, cmd_cd, rsp_valid, refresh_pixel, busy;
  logic       seg_reverse, com_reverse, hold_ok, segrev_m, comrev_m;
  logic [7:0] cmd_data, rsp_data, refresh_seg, col_m, hold_m, kc, c;
  logic [6:0] refresh_com;
  logic [5:0] start_line, start_m;
  logic [3:0] page_m, pg;
  logic [7:0] mem [9][132];
  int         n_errors = 0;
  int         checks = 0;
  int         cycles = 0;
  int         n_wr = 0;
  int         busy_cyc = 0;
  int         seed;
  //////////////////////////////////////////////////////////////////////
  // Both ends and the checker
  lcd_bus_if bus_if ();
  lcd_port_host i_lcd_port_host (.clk(clk), .nrst(nrst), .parallel_mode(parallel_mode),
    .bus_style(bus_style), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_read(cmd_read), .cmd_cd(cmd_cd), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .bus(bus_if));
  lcd_port_dev i_lcd_port_dev (.clk(clk), .nrst(nrst), .bus(bus_if),
    .refresh_com(refresh_com), .refresh_seg(refresh_seg), .refresh_pixel(refresh_pixel),
    .busy(busy), .seg_reverse(seg_reverse), .com_reverse(com_reverse),
    .start_line(start_line));
  lcd_host_port_chk i_lcd_host_port_chk (.clk(clk), .nrst(nrst),
    .parallel_select(bus_if.parallel_select), .bus_style_strap(bus_if.bus_style_strap),
    .chip_select_low_active_n(bus_if.chip_select_low_active_n),
    .chip_select_high_active(bus_if.chip_select_high_active),
    .command_data_select(bus_if.command_data_select), .rd_e(bus_if.rd_e),
    .wr_rw(bus_if.wr_rw), .data_host(bus_if.data_host), .data_host_oe(bus_if.data_host_oe),
    .data_dev(bus_if.data_dev), .data_dev_oe(bus_if.data_dev_oe));
  //////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (busy === 1'b1) busy_cyc <= busy_cyc + 1;
    if (cycles == 40000) begin
      n_errors++;
      final_report();
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Compare and report
  task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte
  task cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit
  task final_report;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////
  // Wait until the host end is idle again
  task idle;
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
  endtask : idle
  // One request on the user port; waits for the answer of a read
  task xfer(input logic rd, input logic cd, input logic [7:0] d,
            output logic [7:0] q, output logic got);
    int n;
    n = 0;
    got = 1'b0;
    q = 8'h00;
    idle();
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read  <= rd;
    cmd_cd    <= cd;
    cmd_data  <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (rd && n < 100) begin
      @(negedge clk);
      n++;
      if (rsp_valid === 1'b1) begin
        got = 1'b1;
        q = rsp_data;
        n = 100;
      end
    end
  endtask : xfer
  // Request plus model of addressing and the read holder
  task op(input logic rd, input logic cd, input logic [7:0] d);
    logic [7:0] q;
    logic       got;
    xfer(rd, cd, d, q, got);
    if (!rd) n_wr++;
    if (!rd && !cd) begin
      if (d[7:4] == 4'h0) col_m = {col_m[7:4], d[3:0]};
      else if (d[7:4] == 4'h1) col_m = {d[3:0], col_m[3:0]};
      else if (d[7:4] == 4'hB) page_m = d[3:0];
      else if (d[7:6] == 2'h1) start_m = d[5:0];
      else if (d[7:1] == 7'h50) segrev_m = d[0];
      else if (d == 8'hC0 || d == 8'hC8) comrev_m = d[3];
      hold_ok = 1'b0;
    end else if (!rd) begin
      if (col_m <= 8'h83) mem[page_m][col_m] = (page_m == 4'h8) ? (d & 8'h01) : d;
      if (col_m < 8'h83) col_m++;
      hold_ok = 1'b0;
    end else if (!parallel_mode) begin
      cmp_bit(got, 1'b0);
    end else if (!cd) begin
      cmp_byte(q, 8'h00);
    end else begin
      if (hold_ok) cmp_byte(q, hold_m);
      hold_m = mem[page_m][col_m];
      hold_ok = 1'b1;
      if (col_m < 8'h83) col_m++;
    end
  endtask : op
  task set_addr(input logic [3:0] p, input logic [7:0] a);
    op(1'b0, 1'b0, {4'hB, p});
    op(1'b0, 1'b0, {4'h1, a[7:4]});
    op(1'b0, 1'b0, {4'h0, a[3:0]});
  endtask : set_addr
  // Expected refresh pixel from line and column mapping
  function automatic logic exp_pix(input int com, input int seg);
    int line;
    line = (start_m + ((com == 64) ? 64 : (comrev_m ? 63 - com : com))) % 65;
    return mem[line / 8][segrev_m ? 131 - seg : seg][line % 8];
  endfunction : exp_pix
  task pix(input int com, input int seg);
    logic e;
    e = exp_pix(com, seg);
    @(posedge clk);
    refresh_com <= 7'(com);
    refresh_seg <= 8'(seg);
    @(posedge clk);
    @(negedge clk);
    if (e !== 1'bx) cmp_bit(refresh_pixel, e);
  endtask : pix
  //////////////////////////////////////////////////////////////////////
  // Main sequence: 8080, 6800, then serial with refresh checks
  initial begin
    seed = 64734;
    nrst = 1'b0;
    parallel_mode = 1'b1;
    bus_style = 1'b0;
    {cmd_valid, cmd_read, cmd_cd, hold_ok, segrev_m, comrev_m} = 6'h00;
    {cmd_data, refresh_seg, col_m, refresh_com, start_m, page_m} = 41'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      idle();
      @(posedge clk);
      parallel_mode <= (m < 2);
      bus_style <= (m == 1);
      repeat (4) @(posedge clk);
      for (int p = 0; p < 2; p++) begin
        pg = p ? 4'h8 : 4'($random(seed) & 7);
        c = p ? 8'h81 : 8'($random(seed) & 8'h7F);
        kc = p ? kc : c;
        set_addr(pg, c);
        repeat (4) op(1'b0, 1'b1, 8'($random(seed)));
        set_addr(pg, c);
        repeat (5) op(1'b1, 1'b1, 8'h00);
        op(1'b1, 1'b0, 8'h00);
      end
    end
    for (int r = 0; r < 2; r++) begin
      op(1'b0, 1'b0, 8'hA0 | 8'(r));
      op(1'b0, 1'b0, r ? 8'hC8 : 8'hC0);
      op(1'b0, 1'b0, 8'h40 | 8'($random(seed) & 8'h3F));
      idle();
      repeat (8) @(posedge clk);
      cmp_bit(seg_reverse, segrev_m);
      cmp_bit(com_reverse, comrev_m);
      cmp_byte({2'h0, start_line}, {2'h0, start_m});
      for (int k = 0; k < 65; k++) pix(k, segrev_m ? 131 - kc : kc);
    end
    cmp_bit(busy_cyc == lcd_pkg::BUSY_CYC * n_wr, 1'b1);
    final_report();
  end
endmodule : lcd_host_port_ram_access_bench
